//--- shared/stb_pkg.sv
// Constants, types and shared functions for the split tenure bus master and its arbiter end.
// Assumes both ends run on one clock and keep identical queues of acknowledged tenures.
// Notes on behaviour
// RULE_01 - Access is address tenure plus data tenure.
// RULE_02 - Tenures independent; data may overlap address.
// RULE_03 - Single beat 64 bits; burst four beats.
// RULE_04 - Narrow 32-bit mode bursts use eight beats.
// RULE_05 - Slave terminates each beat; last ends tenure.
// RULE_06 - Address acknowledge either completes or forces retry.
// RULE_07 - Address-only transactions carry no data tenure.
// RULE_08 - Data tenures follow own address order.
// RULE_09 - Write priority lets pending write go first.
// RULE_10 - Data order follows address order otherwise.
// RULE_11 - Busy lines driven only while owning bus. In stream mode the master drives data busy in every cycle.
// RULE_12 - Request asserted while address bus wanted.
// RULE_13 - Address busy asserted after qualified grant.
// RULE_14 - Data busy asserted after qualified data grant.
// RULE_15 - Streaming mode drives data busy as output.
// RULE_16 - Request and grants are per master lines.
// RULE_17 - Arbiter grants next address before data ends.
// RULE_18 - Outstanding transactions limited to configured depth.
// RULE_19 - Everything sampled and driven on rising edge.
// RULE_20 - Arbitration and busy lines are active low.
// RULE_21 - Address busy negated one cycle after acknowledge.
// RULE_22 - Arbiter allows one address bus owner.
// RULE_23 - One data grant, in acknowledged order.
package stb_pkg;
   localparam int ADDR_W        = 32;
   localparam int DATA_W        = 64;
   localparam int FIFO_DEPTH    = 16;
   localparam int LEVEL_W       = 5;
   localparam int QUEUE_DEPTH   = 3;
   localparam int BEAT_W        = 4;
   localparam logic [BEAT_W-1:0] BEATS_SINGLE = 4'h1;
   localparam logic [BEAT_W-1:0] BEATS_WIDE   = 4'h4;
   localparam logic [BEAT_W-1:0] BEATS_NARROW = 4'h8;
   localparam logic [1:0] LIMIT_SHALLOW = 2'h2;
   localparam logic [1:0] LIMIT_DEEP    = 2'h3;

   typedef enum logic [1:0] {
      STB_READ      = 2'h0,
      STB_WRITE     = 2'h1,
      STB_ADDR_ONLY = 2'h2
   } stb_kind_type;

   typedef struct packed {
      logic write;
      logic burst;
   } stb_entry_type;

   typedef stb_entry_type [QUEUE_DEPTH-1:0] stb_queue_type;

   // Oldest entry, or with write priority the oldest write behind a leading read.
   function automatic logic [1:0] stb_pick(stb_queue_type q, logic [1:0] cnt, logic ahead);
      logic [1:0] idx;
      idx = 2'h0;
      if (ahead && !q[0].write) begin // RULE_09
         for (int i = QUEUE_DEPTH - 1; i > 0; i--) begin
            if (2'(i) < cnt && q[i].write) begin
               idx = 2'(i);
            end
         end
      end
      return idx;
   endfunction

   function automatic logic [BEAT_W-1:0] stb_beats(logic burst, logic narrow);
      return !burst ? BEATS_SINGLE : (narrow ? BEATS_NARROW : BEATS_WIDE); // RULE_03 RULE_04
   endfunction

   function automatic stb_queue_type stb_remove(stb_queue_type q, logic [1:0] idx);
      stb_queue_type r;
      r = q;
      for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
         if (2'(i) >= idx) begin
            r[i] = q[i+1];
         end
      end
      return r;
   endfunction
endpackage

//--- shared/stb_if.sv
// Bus lines between one master and the central arbiter with its slave.
// Assumes pull-ups: a busy line reads negated unless its owner drives it low.
`timescale 1ns/10ps
`default_nettype none
interface stb_if;
   import stb_pkg::*;
   logic                address_bus_request_n;
   logic                address_bus_grant_n;
   logic                address_bus_busy_o;
   logic                address_bus_busy_oe;
   logic                address_bus_busy_n;
   logic                data_bus_grant_n;
   logic                write_ahead_priority_n;
   logic                data_bus_busy_o;
   logic                data_bus_busy_oe;
   logic                data_bus_busy_n;
   logic                transfer_start_n;
   logic                address_acknowledge_n;
   logic                address_retry_n;
   logic                data_termination_n;
   stb_kind_type        transfer_kind;
   logic                transfer_burst;
   logic [ADDR_W-1:0]   transfer_addr;
   logic [DATA_W-1:0]   data_wr;
   logic [DATA_W-1:0]   data_rd;

   // Pull-up resolution of the shared busy lines.
   assign address_bus_busy_n = !(address_bus_busy_oe && !address_bus_busy_o);
   assign data_bus_busy_n    = !(data_bus_busy_oe && !data_bus_busy_o);

   modport master (
      output address_bus_request_n, address_bus_busy_o, address_bus_busy_oe,
      output data_bus_busy_o, data_bus_busy_oe, transfer_start_n,
      output transfer_kind, transfer_burst, transfer_addr, data_wr,
      input  address_bus_grant_n, address_bus_busy_n, data_bus_grant_n,
      input  write_ahead_priority_n, data_bus_busy_n, address_acknowledge_n,
      input  address_retry_n, data_termination_n, data_rd
   );
   modport arbiter (
      input  address_bus_request_n, address_bus_busy_n, data_bus_busy_n,
      input  transfer_start_n, transfer_kind, transfer_burst, transfer_addr, data_wr,
      output address_bus_grant_n, data_bus_grant_n, write_ahead_priority_n,
      output address_acknowledge_n, address_retry_n, data_termination_n, data_rd
   );
endinterface
`default_nettype wire

//--- logic/stb_master.sv
// Bus master end: request FIFO for write data, address tenure and data tenure engines.
// Assumes the arbiter end on the same clock; no synchronisers on its lines.
`timescale 1ns/10ps
`default_nettype none
module stb_fifo
   import stb_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             clk_en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [PTR_W:0]   level_ff;
   logic [PTR_W-1:0] nxt_wr_ptr;
   logic [PTR_W-1:0] nxt_rd_ptr;
   logic [PTR_W:0]   nxt_level;
   logic             push;
   logic             pop;

   assign in_ready  = level_ff != (PTR_W+1)'(DEPTH);
   assign out_valid = level_ff != '0;
   assign out_data  = mem_ff[rd_ptr_ff];
   assign level     = level_ff;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      nxt_level  = level_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff  <= '0;
      end else if (clk_en) begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         level_ff  <= nxt_level;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end
endmodule // stb_fifo

module stb_master
   import stb_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   stb_if.master                  bus,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire stb_kind_type      req_kind,
   input  wire logic              req_burst,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic              wr_valid,
   output logic                   wr_ready,
   input  wire logic [DATA_W-1:0] wr_data,
   output logic                   rd_valid,
   output logic [DATA_W-1:0]      rd_data,
   output logic                   rd_last,
   input  wire logic              narrow_mode,
   input  wire logic              deep_pipe,
   input  wire logic              stream_mode
);
   typedef enum logic [3:0] {
      A_IDLE = 4'h1,
      A_REQ  = 4'h2,
      A_OWN  = 4'h4,
      A_GAP  = 4'h8
   } stb_astate_type;

   typedef enum logic [2:0] {
      D_IDLE = 3'h1,
      D_WAIT = 3'h2,
      D_XFER = 3'h4
   } stb_dstate_type;

   stb_astate_type     a_state_ff;
   stb_astate_type     nxt_a_state;
   stb_kind_type       kind_ff;
   stb_kind_type       nxt_kind;
   logic               burst_ff;
   logic               nxt_burst;
   logic [ADDR_W-1:0]  addr_ff;
   logic [ADDR_W-1:0]  nxt_addr;
   logic               ts_ff;
   logic               nxt_ts;
   logic               retry_ff;
   logic               nxt_retry;
   logic               push;
   stb_dstate_type     d_state_ff;
   stb_dstate_type     nxt_d_state;
   stb_queue_type      q_ff;
   stb_queue_type      nxt_q;
   logic [1:0]         q_cnt_ff;
   logic [1:0]         nxt_q_cnt;
   logic [1:0]         sel_ff;
   logic [1:0]         nxt_sel;
   logic [BEAT_W-1:0]  beat_ff;
   logic [BEAT_W-1:0]  nxt_beat;
   logic               rd_valid_ff;
   logic               nxt_rd_valid;
   logic [DATA_W-1:0]  rd_data_ff;
   logic [DATA_W-1:0]  nxt_rd_data;
   logic               rd_last_ff;
   logic               nxt_rd_last;
   logic [1:0]         pick;
   logic [BEAT_W-1:0]  pick_beats;
   logic               data_grant_ok;
   logic               term;
   logic               fifo_pop;
   logic [LEVEL_W-1:0] fifo_level;

   stb_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (),
      .out_ready (fifo_pop),
      .out_data  (bus.data_wr),
      .level     (fifo_level)
   );

   assign req_ready = (a_state_ff == A_IDLE) &&
                      (q_cnt_ff < (deep_pipe ? LIMIT_DEEP : LIMIT_SHALLOW)); // RULE_18
   assign bus.address_bus_request_n = !(a_state_ff == A_REQ); // RULE_12 RULE_20
   assign bus.address_bus_busy_oe   = a_state_ff == A_OWN; // RULE_11
   assign bus.address_bus_busy_o    = 1'b0;
   assign bus.transfer_start_n      = !ts_ff;
   assign bus.transfer_kind         = kind_ff;
   assign bus.transfer_burst        = burst_ff;
   assign bus.transfer_addr         = addr_ff;

   always_comb begin
      nxt_a_state = a_state_ff;
      nxt_kind    = kind_ff;
      nxt_burst   = burst_ff;
      nxt_addr    = addr_ff;
      nxt_ts      = 1'b0;
      nxt_retry   = retry_ff;
      push        = 1'b0;
      unique case (a_state_ff)
         A_IDLE: if (req_valid && req_ready) begin
            nxt_a_state = A_REQ;
            nxt_kind    = req_kind;
            nxt_burst   = req_burst && req_kind != STB_ADDR_ONLY;
            nxt_addr    = req_addr;
         end
         A_REQ: if (!bus.address_bus_grant_n && bus.address_bus_busy_n) begin // RULE_13
            nxt_a_state = A_OWN;
            nxt_ts      = 1'b1;
         end
         A_OWN: if (!bus.address_acknowledge_n) begin // RULE_06
            nxt_a_state = A_GAP;
            nxt_retry   = !bus.address_retry_n;
            push        = bus.address_retry_n && kind_ff != STB_ADDR_ONLY; // RULE_07 RULE_01
         end
         A_GAP: nxt_a_state = retry_ff ? A_REQ : A_IDLE; // RULE_21
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin // RULE_19
      if (sys_rst) begin
         a_state_ff <= A_IDLE;
         kind_ff    <= STB_READ;
         burst_ff   <= 1'b0;
         addr_ff    <= '0;
         ts_ff      <= 1'b0;
         retry_ff   <= 1'b0;
      end else if (clk_en) begin
         a_state_ff <= nxt_a_state;
         kind_ff    <= nxt_kind;
         burst_ff   <= nxt_burst;
         addr_ff    <= nxt_addr;
         ts_ff      <= nxt_ts;
         retry_ff   <= nxt_retry;
      end
   end

   assign term          = !bus.data_termination_n;
   assign pick          = stb_pick(q_ff, q_cnt_ff, !bus.write_ahead_priority_n); // RULE_09
   assign pick_beats    = stb_beats(q_ff[pick].burst, narrow_mode);
   assign data_grant_ok = !bus.data_bus_grant_n && (stream_mode || bus.data_bus_busy_n); // RULE_14
   assign fifo_pop      = d_state_ff == D_XFER && q_ff[sel_ff].write && term;
   assign bus.data_bus_busy_oe = stream_mode || d_state_ff == D_XFER; // RULE_15 RULE_11
   assign bus.data_bus_busy_o  = !(d_state_ff == D_XFER);
   assign rd_valid = rd_valid_ff;
   assign rd_data  = rd_data_ff;
   assign rd_last  = rd_last_ff;

   // The data engine runs beside the address engine, so tenures overlap.
   always_comb begin // RULE_02
      nxt_d_state  = d_state_ff;
      nxt_q        = q_ff;
      nxt_q_cnt    = q_cnt_ff;
      nxt_sel      = sel_ff;
      nxt_beat     = beat_ff;
      nxt_rd_valid = 1'b0;
      nxt_rd_data  = rd_data_ff;
      nxt_rd_last  = 1'b0;
      unique case (d_state_ff)
         D_IDLE: if (q_cnt_ff != 2'h0) begin
            nxt_d_state = D_WAIT;
         end
         D_WAIT: if (data_grant_ok &&
                     (!q_ff[pick].write || fifo_level >= LEVEL_W'(pick_beats))) begin
            nxt_d_state = D_XFER;
            nxt_sel     = pick; // RULE_10 RULE_08
            nxt_beat    = pick_beats;
         end
         D_XFER: if (term) begin // RULE_05
            nxt_beat = beat_ff - 4'h1;
            if (!q_ff[sel_ff].write) begin
               nxt_rd_valid = 1'b1;
               nxt_rd_data  = bus.data_rd;
               nxt_rd_last  = beat_ff == 4'h1;
            end
            if (beat_ff == 4'h1) begin
               nxt_d_state = D_IDLE;
               nxt_q       = stb_remove(q_ff, sel_ff);
               nxt_q_cnt   = q_cnt_ff - 2'h1;
            end
         end
      endcase
      if (push) begin
         nxt_q[nxt_q_cnt].write = kind_ff == STB_WRITE;
         nxt_q[nxt_q_cnt].burst = burst_ff;
         nxt_q_cnt              = nxt_q_cnt + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         d_state_ff  <= D_IDLE;
         q_ff        <= '0;
         q_cnt_ff    <= 2'h0;
         sel_ff      <= 2'h0;
         beat_ff     <= '0;
         rd_valid_ff <= 1'b0;
         rd_data_ff  <= '0;
         rd_last_ff  <= 1'b0;
      end else if (clk_en) begin
         d_state_ff  <= nxt_d_state;
         q_ff        <= nxt_q;
         q_cnt_ff    <= nxt_q_cnt;
         sel_ff      <= nxt_sel;
         beat_ff     <= nxt_beat;
         rd_valid_ff <= nxt_rd_valid;
         rd_data_ff  <= nxt_rd_data;
         rd_last_ff  <= nxt_rd_last;
      end
   end
endmodule // stb_master
`default_nettype wire

//--- logic/stb_arbiter.sv
// Arbiter end: address and data grants, address acknowledge and beat termination.
// Assumes one master on the bus, on the same clock.
`timescale 1ns/10ps
`default_nettype none
module stb_arbiter
   import stb_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   stb_if.arbiter                 bus,
   input  wire logic              narrow_mode,
   input  wire logic              deep_pipe,
   input  wire logic              retry_req,
   input  wire logic              write_ahead,
   input  wire logic [DATA_W-1:0] rd_beat_data,
   output logic                   addr_valid,
   output logic [ADDR_W-1:0]      addr_out,
   output stb_kind_type           kind_out,
   output logic                   burst_out,
   output logic                   beat_valid,
   output logic                   beat_write,
   output logic                   beat_last,
   output logic [DATA_W-1:0]      beat_data
);
   typedef enum logic [2:0] {
      G_IDLE  = 3'h1,
      G_GRANT = 3'h2,
      G_XFER  = 3'h4
   } stb_gstate_type;

   logic              bg_ff;
   logic              nxt_bg;
   logic              address_acknowledge_ff;
   logic              retry_ff;
   logic [ADDR_W-1:0] addr_ff;
   stb_kind_type      kind_ff;
   logic              burst_ff;
   logic              push;
   stb_gstate_type    g_state_ff;
   stb_gstate_type    nxt_g_state;
   stb_queue_type     q_ff;
   stb_queue_type     nxt_q;
   logic [1:0]        q_cnt_ff;
   logic [1:0]        nxt_q_cnt;
   logic [1:0]        sel_ff;
   logic [1:0]        nxt_sel;
   logic [BEAT_W-1:0] beat_ff;
   logic [BEAT_W-1:0] nxt_beat;
   logic              dbg_ff;
   logic              nxt_dbg;
   logic              write_ahead_priority_ff;
   logic              nxt_write_ahead_priority;
   logic              term_ff;
   logic              nxt_term;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic              bv_ff;
   logic              bw_ff;
   logic              bl_ff;
   logic [DATA_W-1:0] bd_ff;

   assign bus.address_bus_grant_n    = !bg_ff; // RULE_16
   assign bus.address_acknowledge_n  = !address_acknowledge_ff;
   assign bus.address_retry_n        = !(address_acknowledge_ff && retry_ff);
   assign bus.data_bus_grant_n       = !dbg_ff;
   assign bus.write_ahead_priority_n = !write_ahead_priority_ff;
   assign bus.data_termination_n     = !term_ff;
   assign bus.data_rd                = rdata_ff;
   assign addr_valid = address_acknowledge_ff && !retry_ff;
   assign addr_out   = addr_ff;
   assign kind_out   = kind_ff;
   assign burst_out  = burst_ff;
   assign beat_valid = bv_ff;
   assign beat_write = bw_ff;
   assign beat_last  = bl_ff;
   assign beat_data  = bd_ff;
   assign push = address_acknowledge_ff && !retry_ff && kind_ff != STB_ADDR_ONLY;

   // Grant only a free address bus, even while a data tenure is still running.
   always_comb begin
      nxt_bg = !bus.address_bus_request_n && bus.address_bus_busy_n && !address_acknowledge_ff &&
               q_cnt_ff < (deep_pipe ? LIMIT_DEEP : LIMIT_SHALLOW); // RULE_22 RULE_17
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bg_ff    <= 1'b0;
         address_acknowledge_ff  <= 1'b0;
         retry_ff <= 1'b0;
         addr_ff  <= '0;
         kind_ff  <= STB_READ;
         burst_ff <= 1'b0;
      end else if (clk_en) begin
         bg_ff   <= nxt_bg;
         address_acknowledge_ff <= !bus.transfer_start_n; // RULE_06
         if (!bus.transfer_start_n) begin
            retry_ff <= retry_req;
            addr_ff  <= bus.transfer_addr;
            kind_ff  <= bus.transfer_kind;
            burst_ff <= bus.transfer_burst;
         end
      end
   end

   always_comb begin
      nxt_g_state = g_state_ff;
      nxt_q       = q_ff;
      nxt_q_cnt   = q_cnt_ff;
      nxt_sel     = sel_ff;
      nxt_beat    = beat_ff;
      nxt_dbg     = dbg_ff;
      nxt_write_ahead_priority    = write_ahead_priority_ff;
      nxt_term    = term_ff;
      nxt_rdata   = rdata_ff;
      unique case (g_state_ff)
         G_IDLE: if (q_cnt_ff != 2'h0 && bus.data_bus_busy_n) begin // RULE_23
            nxt_g_state = G_GRANT;
            nxt_dbg     = 1'b1;
            nxt_write_ahead_priority    = write_ahead;
         end
         G_GRANT: if (!bus.data_bus_busy_n) begin
            nxt_g_state = G_XFER;
            nxt_dbg     = 1'b0;
            nxt_write_ahead_priority    = 1'b0;
            nxt_beat    = stb_beats(q_ff[sel_ff].burst, narrow_mode);
            nxt_term    = 1'b1;
            nxt_rdata   = rd_beat_data;
         end else begin
            nxt_sel = stb_pick(q_ff, q_cnt_ff, write_ahead_priority_ff); // RULE_09 RULE_08
         end
         G_XFER: if (term_ff) begin // RULE_05
            nxt_beat  = beat_ff - 4'h1;
            nxt_rdata = rd_beat_data;
            if (beat_ff == 4'h1) begin
               nxt_g_state = G_IDLE;
               nxt_term    = 1'b0;
               nxt_q       = stb_remove(q_ff, sel_ff);
               nxt_q_cnt   = q_cnt_ff - 2'h1;
            end
         end
      endcase
      if (push) begin
         nxt_q[nxt_q_cnt].write = kind_ff == STB_WRITE;
         nxt_q[nxt_q_cnt].burst = burst_ff;
         nxt_q_cnt              = nxt_q_cnt + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         g_state_ff <= G_IDLE;
         q_ff       <= '0;
         q_cnt_ff   <= 2'h0;
         sel_ff     <= 2'h0;
         beat_ff    <= '0;
         dbg_ff     <= 1'b0;
         write_ahead_priority_ff    <= 1'b0;
         term_ff    <= 1'b0;
         rdata_ff   <= '0;
         bv_ff      <= 1'b0;
         bw_ff      <= 1'b0;
         bl_ff      <= 1'b0;
         bd_ff      <= '0;
      end else if (clk_en) begin
         g_state_ff <= nxt_g_state;
         q_ff       <= nxt_q;
         q_cnt_ff   <= nxt_q_cnt;
         sel_ff     <= nxt_sel;
         beat_ff    <= nxt_beat;
         dbg_ff     <= nxt_dbg;
         write_ahead_priority_ff    <= nxt_write_ahead_priority;
         term_ff    <= nxt_term;
         rdata_ff   <= nxt_rdata;
         bv_ff      <= term_ff;
         bw_ff      <= q_ff[sel_ff].write;
         bl_ff      <= term_ff && beat_ff == 4'h1;
         bd_ff      <= bus.data_wr;
      end
   end
endmodule // stb_arbiter
`default_nettype wire

//--- sim/stb_properties.sv
// Concurrent checks on the bus lines between the master and arbiter ends.
// Assumes the interface signals are wired in by name beside the interface.
`timescale 1ns/10ps
`default_nettype none
module stb_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic address_bus_request_n,
   input wire logic address_bus_grant_n,
   input wire logic address_bus_busy_n,
   input wire logic data_bus_grant_n,
   input wire logic data_bus_busy_n,
   input wire logic transfer_start_n,
   input wire logic address_acknowledge_n,
   input wire logic data_termination_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_start; $fell(transfer_start_n); endsequence
   sequence s_ack; !address_acknowledge_n; endsequence
   property p_ts_abb; !transfer_start_n |-> !address_bus_busy_n; endproperty
   a_ts_abb: assert property (p_ts_abb) else $error("start without busy");
   property p_ts_grant; s_start |-> $past(address_bus_grant_n) == 1'b0; endproperty
   a_ts_grant: assert property (p_ts_grant) else $error("start without grant");
   property p_ts_pulse; s_start |=> transfer_start_n; endproperty
   a_ts_pulse: assert property (p_ts_pulse) else $error("start too long");
   property p_address_acknowledge; s_start |-> ##[1:4] s_ack; endproperty
   a_address_acknowledge: assert property (p_address_acknowledge) else $error("no acknowledge");
   property p_abb_free; s_ack |=> address_bus_busy_n; endproperty
   a_abb_free: assert property (p_abb_free) else $error("busy held");
   property p_req_idle; !address_bus_request_n |-> address_bus_busy_n; endproperty
   a_req_idle: assert property (p_req_idle) else $error("request while owner");
   property p_dbb_grant; $fell(data_bus_busy_n) |-> $past(data_bus_grant_n) == 1'b0; endproperty
   a_dbb_grant: assert property (p_dbb_grant) else $error("data busy ungranted");
   property p_term_dbb; !data_termination_n |-> !data_bus_busy_n; endproperty
   a_term_dbb: assert property (p_term_dbb) else $error("beat off tenure");
endmodule // stb_properties
`default_nettype wire

//--- sim/split_tenure_bus_arbitration_test.sv
// Bench joining master and arbiter ends through the bus interface.
// Assumes one 200 MHz clock; random values come from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module split_tenure_bus_arbitration_test;
   import stb_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid, req_burst, wr_valid, narrow_mode, deep_pipe, stream_mode;
   logic retry_req, write_ahead, req_ready, wr_ready, rd_valid, rd_last;
   logic addr_valid, beat_valid, beat_write, beat_last, burst_out;
   logic [ADDR_W-1:0] req_addr, addr_out;
   logic [DATA_W-1:0] wr_data, rd_data, beat_data, beat_prev, beat_prev2;
   logic [DATA_W-1:0] rd_beat_data = 64'h9d5d;
   logic [31:0] seed = 32'h9d5d;
   stb_kind_type req_kind, kind_out;
   int n_fail = 0;
   int total_checks = 0;
   logic [64:0] q_ad[$], q_wr[$];
   logic q_rd[$];
   stb_if bus ();
   stb_master i_stb_master (.clk, .sys_rst, .clk_en(1'b1), .bus(bus.master), .req_valid,
      .req_ready, .req_kind, .req_burst, .req_addr, .wr_valid, .wr_ready, .wr_data, .rd_valid,
      .rd_data, .rd_last, .narrow_mode, .deep_pipe, .stream_mode);
   stb_arbiter i_stb_arbiter (.clk, .sys_rst, .clk_en(1'b1), .bus(bus.arbiter), .narrow_mode,
      .deep_pipe, .retry_req, .write_ahead, .rd_beat_data, .addr_valid, .addr_out, .kind_out,
      .burst_out, .beat_valid, .beat_write, .beat_last, .beat_data);
   stb_properties i_stb_properties (.clk, .sys_rst,
      .address_bus_request_n(bus.address_bus_request_n),
      .address_bus_grant_n(bus.address_bus_grant_n),
      .address_bus_busy_n(bus.address_bus_busy_n), .data_bus_grant_n(bus.data_bus_grant_n),
      .data_bus_busy_n(bus.data_bus_busy_n), .transfer_start_n(bus.transfer_start_n),
      .address_acknowledge_n(bus.address_acknowledge_n),
      .data_termination_n(bus.data_termination_n));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic test_done();
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string what, logic [64:0] exp, logic [64:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tmo(int k);
      if (k >= 400) begin
         n_fail++;
         test_done();
      end
   endtask
   task automatic push_wr(int n, int g);
      int k;
      @(negedge clk);
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         wr_data = {seed, ~seed};
         wr_valid = 1'b1;
         q_wr.push_back({1'(i % g == g - 1), wr_data});
         for (k = 0; k < 400 && wr_ready !== 1'b1; k++) @(negedge clk);
         tmo(k);
         @(negedge clk);
      end
      wr_valid = 1'b0;
   endtask
   task automatic req(stb_kind_type kind, logic burst, logic pre);
      int k;
      int n;
      n = !burst ? 1 : narrow_mode ? 8 : 4;
      if (kind == STB_WRITE && !pre) push_wr(n, n);
      if (kind == STB_READ) for (k = 0; k < n; k++) q_rd.push_back(k == n - 1);
      @(negedge clk);
      seed = lfsr(seed);
      req_kind = kind;
      req_burst = burst;
      req_addr = seed;
      req_valid = 1'b1;
      q_ad.push_back(65'({kind, burst && kind != STB_ADDR_ONLY, seed}));
      for (k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge clk);
      tmo(k);
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic drain();
      int k;
      for (k = 0; k < 400 && q_ad.size() + q_rd.size() + q_wr.size() > 0; k++) @(negedge clk);
      tmo(k);
   endtask
   always #2.5 clk = ~clk;
   // Read data, retries and write priority change every cycle from the generator.
   always @(negedge clk) begin
      rd_beat_data <= {rd_beat_data[31:0], lfsr(rd_beat_data[31:0])};
      retry_req <= rd_beat_data[3] & rd_beat_data[7];
      write_ahead <= rd_beat_data[9];
   end
   always @(posedge clk) begin
      beat_prev <= rd_beat_data;
      beat_prev2 <= beat_prev;
      if (addr_valid) chk("address", q_ad.pop_front(), 65'({kind_out, burst_out, addr_out}));
      if (rd_valid) chk("read beat", {q_rd.pop_front(), beat_prev2}, {rd_last, rd_data});
      if (beat_valid && beat_write) chk("write beat", q_wr.pop_front(), {beat_last, beat_data});
   end
   initial begin
      {req_valid, req_burst, wr_valid, retry_req, write_ahead} = '0;
      {narrow_mode, deep_pipe, stream_mode} = '0;
      req_kind = STB_READ;
      req_addr = '0;
      wr_data = '0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      for (int m = 0; m < 8; m++) begin
         {narrow_mode, deep_pipe, stream_mode} = 3'(m);
         req(STB_READ, 1'b0, 1'b0);
         req(STB_WRITE, 1'b1, 1'b0);
         req(STB_ADDR_ONLY, 1'b1, 1'b0);
         req(STB_READ, 1'b1, 1'b0);
         for (int r = 0; r < 6; r++) begin
            seed = lfsr(seed);
            req(seed[1:0] == 2'h3 ? STB_WRITE : stb_kind_type'(seed[1:0]), seed[2], 1'b0);
         end
         drain();
      end
      narrow_mode = 1'b0;
      push_wr(16, 4);
      chk("fifo ready", 65'(0), 65'(wr_ready));
      repeat (4) req(STB_WRITE, 1'b1, 1'b1);
      drain();
      test_done();
   end
endmodule // split_tenure_bus_arbitration_test
`default_nettype wire
